/* File: rtl/page_adjust_defs.vh */
`ifndef PAGE_ADJUST_DEFS_VH
`define PAGE_ADJUST_DEFS_VH

// Widths
`define PAGE_W            10
`define EA_W              16
`define EA_WINDOW_BIT     15

// Addressing modes reported by the address generator
`define MODE_W            2
`define MODE_LINEAR       2'h0
`define MODE_REG_OFFSET   2'h1
`define MODE_MODULO       2'h2
`define MODE_BIT_REVERSE  2'h3

// Page boundary values
`define PAGE_ZERO         10'h000
`define PAGE_FIRST        10'h001
`define PAGE_EXT_LAST       10'h1ff
`define PAGE_PROG_FIRST     10'h200
`define PAGE_PROG_LSW_LAST  10'h2ff
`define PAGE_PROG_MSB_FIRST 10'h300
`define PAGE_PROG_MSB_LAST  10'h3ff
`define PAGE_ONE          10'h001

// Reset values of the page registers
`define READ_PAGE_RESET   10'h001
`define WRITE_PAGE_RESET  10'h001

`endif

/* File: rtl/page_step.v */
`timescale 1ns/1ps
`default_nettype none
`include "page_adjust_defs.vh"

module page_step #(
  parameter PAGE_W = `PAGE_W
) (
  input  wire [PAGE_W-1:0] page,
  input  wire              is_write,
  input  wire              in_window,
  input  wire [1:0]        mode,
  input  wire              overflow,
  input  wire              underflow,
  input  wire              ea_bit_in,
  output reg  [PAGE_W-1:0] page_next,
  output reg               ea_bit_next
);

  // Next page and window bit for one access through one page register
  always @* begin
    page_next   = page;
    ea_bit_next = ea_bit_in;
    if (in_window && (overflow || underflow)) begin
      if (mode != `MODE_LINEAR) begin
        // Wrap inside the current page, page untouched
        ea_bit_next = 1'b1;
      end else if (overflow) begin
        ea_bit_next = 1'b0;
        if (page == `PAGE_EXT_LAST) begin
          page_next = page;
          if (is_write) begin
            page_next = page;
          end
        end else if (!is_write && page == `PAGE_PROG_LSW_LAST) begin
          page_next   = `PAGE_PROG_MSB_FIRST;
          ea_bit_next = 1'b1;
        end else if (!is_write && page == `PAGE_PROG_MSB_LAST) begin
          page_next = page;
        end else begin
          page_next   = page + `PAGE_ONE;
          ea_bit_next = 1'b1;
        end
      end else begin
        ea_bit_next = 1'b0;
        if (!is_write && page == `PAGE_FIRST) begin
          page_next = page;
        end else if (!is_write && page == `PAGE_PROG_FIRST) begin
          page_next = page;
        end else if (!is_write && page == `PAGE_PROG_MSB_FIRST) begin
          page_next   = `PAGE_PROG_LSW_LAST;
          ea_bit_next = 1'b1;
        end else begin
          page_next   = page - `PAGE_ONE;
          ea_bit_next = 1'b1;
        end
      end
    end
  end

endmodule // page_step

`default_nettype wire

/* File: rtl/paged_data_address_adjust.v */
// Notes on behaviour
// - Separate page registers for reads and writes
// - Page crossing first clears effective address bit 15
// - Crossing only from window page, linear modes
// - Overflow increments page, sets bit 15
// - Underflow decrements page, sets bit 15
// - Offset, modulo, bit-reverse: set bit, keep page
// - Read overflow at 0x1FF: keep, clear bit
// - Write overflow at 0x1FF: keep, clear bit
// - Read overflow at 0x2FF: go 0x300, keep bit
// - Read overflow at 0x3FF: keep, clear bit
// - Read underflow at 0x001: keep, clear bit
// - Read underflow at 0x200: keep, clear bit
// - Read underflow at 0x300: go 0x2FF, keep bit
// - Cleared bit 15 targets base data space
// - Window access with page zero traps
// - Writes into program window trap
`timescale 1ns/1ps
`default_nettype none
`include "page_adjust_defs.vh"

module paged_data_address_adjust #(
  parameter PAGE_W = `PAGE_W,
  parameter EA_W   = `EA_W
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              req_valid,
  input  wire              req_write,
  input  wire [1:0]        req_mode,
  input  wire [EA_W-1:0]   req_ea,
  input  wire              req_in_window,
  input  wire              req_overflow,
  input  wire              req_underflow,
  input  wire              load_valid,
  input  wire              load_write_page,
  input  wire [PAGE_W-1:0] load_value,
  output reg               resp_valid,
  output reg  [EA_W-1:0]   resp_ea,
  output reg  [PAGE_W-1:0] resp_page,
  output reg               resp_base_space,
  output reg               resp_addr_error,
  output reg  [PAGE_W-1:0] read_page_select,
  output reg  [PAGE_W-1:0] write_page_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Internal nets

  // Next values of the page registers and the response
  reg  [PAGE_W-1:0] active_page_select;
  reg  [PAGE_W-1:0] read_page_next;
  reg  [PAGE_W-1:0] write_page_next;
  reg               trap_next;
  reg  [EA_W-1:0]   ea_next;
  reg               base_next;

  // Trap causes, kept apart for debug
  reg               trap_page_zero;
  reg               trap_prog_write;

  // Boundary arithmetic results
  wire [PAGE_W-1:0] step_page;
  wire              step_ea_bit;

  // Request and load decode
  wire              read_access;
  wire              write_access;
  wire              read_load;
  wire              write_load;
  wire              window_start;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  // Which register an access or a load touches this cycle
  assign read_access  = req_valid & ~req_write;
  assign write_access = req_valid & req_write;
  assign read_load    = load_valid & ~load_write_page;
  assign write_load   = load_valid & load_write_page;

  // A crossing only counts when the unmodified address sat in a window
  // page; a base-space address never moves a page register
  assign window_start = req_in_window & req_ea[`EA_WINDOW_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Page selection for the current request

  // Reads use one register and writes the other
  always @* begin
    if (req_write) begin
      active_page_select = write_page_select;
    end else begin
      active_page_select = read_page_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boundary arithmetic

  // One step unit serves both registers; only one is used per access
  page_step #(
    .PAGE_W (PAGE_W)
  ) u_step (
    .page        (active_page_select),
    .is_write    (req_write),
    .in_window   (window_start),
    .mode        (req_mode),
    .overflow    (req_overflow),
    .underflow   (req_underflow),
    .ea_bit_in   (req_ea[`EA_WINDOW_BIT]),
    .page_next   (step_page),
    .ea_bit_next (step_ea_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Adjusted address

  // Only bit 15 is touched; the low bits already wrapped inside the
  // generator, which is what makes the window look linear
  always @* begin
    ea_next                 = req_ea;
    ea_next[`EA_WINDOW_BIT] = step_ea_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page register updates

  // The read register follows a read access; a same-cycle load overrides
  // the adjustment so software always sees the value it wrote
  always @* begin
    read_page_next = read_page_select;
    if (read_access) begin
      read_page_next = step_page;
    end
    if (read_load) begin
      read_page_next = load_value;
    end
  end

  // The write register behaves the same way for write accesses
  always @* begin
    write_page_next = write_page_select;
    if (write_access) begin
      write_page_next = step_page;
    end
    if (write_load) begin
      write_page_next = load_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address error detection

  // Checked on the final address and the page the access really lands in;
  // each cause is kept apart so a waveform shows which one fired
  always @* begin
    trap_page_zero  = 1'b0;
    trap_prog_write = 1'b0;
    if (ea_next[`EA_WINDOW_BIT]) begin
      // Page zero has no window behind it
      trap_page_zero  = (step_page == `PAGE_ZERO);
      // The program window can only be read, never written
      trap_prog_write = req_write && (step_page >= `PAGE_PROG_FIRST);
    end
    trap_next = trap_page_zero | trap_prog_write;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Space select

  // A boundary case that clears bit 15 drops the access into base data
  // space; a set bit keeps it in the window of the active page register
  always @* begin
    base_next = ~ea_next[`EA_WINDOW_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page registers

  // Both registers reset to the first extended page rather than page zero,
  // so an access right after reset does not trap
  always @(posedge clk) begin
    if (!rst_n) begin
      read_page_select  <= `READ_PAGE_RESET;
      write_page_select <= `WRITE_PAGE_RESET;
    end else begin
      read_page_select  <= read_page_next;
      write_page_select <= write_page_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response

  // Valid and error are one-cycle pulses; the error is gated by the request
  // so a stale trap cannot show on an idle cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      resp_valid      <= 1'b0;
      resp_addr_error <= 1'b0;
    end else begin
      resp_valid      <= req_valid;
      resp_addr_error <= req_valid & trap_next;
    end
  end

  // Address, page and space flag hold until the next request, so a slow
  // consumer can still pick them up after the valid pulse
  always @(posedge clk) begin
    if (!rst_n) begin
      resp_ea         <= {EA_W{1'b0}};
      resp_page       <= {PAGE_W{1'b0}};
      resp_base_space <= 1'b0;
    end else if (req_valid) begin
      resp_ea         <= ea_next;
      resp_page       <= step_page;
      resp_base_space <= base_next;
    end
  end

endmodule // paged_data_address_adjust

`default_nettype wire

/* File: bench/page_adjust_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module page_adjust_checker #(parameter PAGE_W = 10, parameter EA_W = 16) (
  input wire logic              clk, rst_n, req_valid, req_write, req_in_window,
  input wire logic              req_overflow, load_valid, resp_valid, resp_base_space,
  input wire logic              resp_addr_error,
  input wire logic [1:0]        req_mode,
  input wire logic [EA_W-1:0]   req_ea, resp_ea,
  input wire logic [PAGE_W-1:0] resp_page, read_page_select, write_page_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Linear read crossing upward out of a window page, no load racing it
  wire lin_up = req_valid && !req_write && req_mode == 2'h0 && req_in_window
                && req_ea[15] && req_overflow && !load_valid;
  ////////////////////////////////////////////////////////////////////////////
  resp_follows_a: assert property (req_valid |=> resp_valid)
    else $error("request without response");
  resp_quiet_a: assert property (!req_valid |=> !resp_valid)
    else $error("response without request");
  base_select_a: assert property (resp_valid |-> resp_base_space == !resp_ea[15])
    else $error("base space flag disagrees with bit 15");
  page_zero_trap_a: assert property (
    resp_valid && resp_ea[15] && resp_page == 0 |-> resp_addr_error)
    else $error("window access on page zero not trapped");
  write_prog_trap_a: assert property (
    resp_valid && resp_ea[15] && $past(req_write) && resp_page >= 10'h200 |-> resp_addr_error)
    else $error("write into program window not trapped");
  read_isolated_a: assert property (
    req_valid && !req_write && !load_valid |=> $stable(write_page_select))
    else $error("read moved the write page");
  write_isolated_a: assert property (
    req_valid && req_write && !load_valid |=> $stable(read_page_select))
    else $error("write moved the read page");
  mode_keeps_page_a: assert property (
    req_valid && req_mode != 2'h0 && req_ea[15] && !load_valid
    |=> $stable(read_page_select) && $stable(write_page_select) && resp_ea[15])
    else $error("non-linear mode changed a page");
  ext_top_a: assert property (
    lin_up && read_page_select == 10'h1ff |=> read_page_select == 10'h1ff && !resp_ea[15])
    else $error("last extended page overflow wrong");
  lsw_top_a: assert property (
    lin_up && read_page_select == 10'h2ff |=> read_page_select == 10'h300 && resp_ea[15])
    else $error("last low-word page overflow wrong");
endmodule // page_adjust_checker
bind paged_data_address_adjust page_adjust_checker #(.PAGE_W(PAGE_W), .EA_W(EA_W)) chk (.*);
`default_nettype wire

/* File: bench/agen_model.sv */
`timescale 1ns/1ps
`default_nettype none
module agen_model (
  input  wire logic        clk,
  output logic             req_valid, req_write, req_in_window, req_overflow, req_underflow,
  output logic             load_valid, load_write_page,
  output logic [1:0]       req_mode,
  output logic [15:0]      req_ea,
  output logic [9:0]       load_value
);
  initial {req_valid, req_write, req_in_window, req_overflow, req_underflow, load_valid,
           load_write_page, req_mode, req_ea, load_value} = '0;
  // One-cycle page load; released value is inverted so nothing stale looks valid
  task automatic load(input logic w, input logic [9:0] v);
    @(posedge clk); #1;
    {load_valid, load_write_page, load_value} = {1'b1, w, v};
    @(posedge clk); #1;
    {load_valid, load_value} = {1'b0, ~v};
  endtask
  // One access pulse, mode and window flag qualify the crossing
  task automatic access(input logic w, input logic [1:0] m, input logic [15:0] ea,
                        input logic iw, input logic ov, input logic un);
    @(posedge clk); #1;
    {req_valid, req_write, req_mode, req_ea, req_in_window, req_overflow, req_underflow} =
      {1'b1, w, m, ea, iw, ov, un};
    @(posedge clk); #1;
    {req_valid, req_ea} = {1'b0, ~ea};
  endtask
endmodule // agen_model
`default_nettype wire

/* File: bench/tb_paged_data_address_adjust.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_paged_data_address_adjust;
  logic        clk = 0, rst_n = 0;
  logic        req_valid, req_write, req_in_window, req_overflow, req_underflow, load_valid;
  logic        load_write_page, resp_valid, resp_base_space, resp_addr_error;
  logic [1:0]  req_mode;
  logic [15:0] req_ea, resp_ea;
  logic [9:0]  load_value, resp_page, read_page_select, write_page_select, rp, wp;
  logic [47:0] q[$];
  int          miscompares = 0, num_checks = 0;
  always #25 clk = ~clk;
  paged_data_address_adjust uut (.*);
  agen_model agen (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [47:0] e, input logic [47:0] s);
    num_checks++;
    if (e !== s) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Load the page, predict the adjusted access, then issue it
  task automatic run(input logic w, input logic [1:0] m, input logic ov, input logic un,
                     input logic iw, input logic [9:0] p);
    logic [9:0] n;
    logic b, e;
    logic [14:0] lo;
    lo = 15'($urandom);
    agen.load(w, p);
    n = p;
    b = 1'b1;
    if (iw && m == 2'h0 && ov) begin
      if (p == 10'h1ff || (!w && p == 10'h3ff)) b = 1'b0;
      else n = p + 10'h001;
    end else if (iw && m == 2'h0 && un) begin
      if (!w && (p == 10'h001 || p == 10'h200)) b = 1'b0;
      else n = p - 10'h001;
    end
    e = b && (n == 10'h000 || (w && n >= 10'h200));
    if (w) wp = n;
    else rp = n;
    q.push_back({e, b, b, lo, n, rp, wp});
    agen.access(w, m, {1'b1, lo}, iw, ov, un);
  endtask
  // Responses are settled by the falling edge
  always @(negedge clk) if (resp_valid === 1'b1) begin
    if (q.size() == 0) cmp("unexpected response", 48'h0, 48'h1);
    else cmp("response", q.pop_front(), {resp_addr_error, resp_ea[15], !resp_base_space,
             resp_ea[14:0], resp_page, read_page_select, write_page_select});
  end
  initial begin
    int r;
    void'($urandom(32'hf76a2c7a));
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    cmp("reset pages", {28'h0, 20'h00401}, {28'h0, read_page_select, write_page_select});
    {rp, wp} = {10'h001, 10'h001};
    run(0, 2'h0, 1, 0, 1, 10'h1ff);
    run(1, 2'h0, 1, 0, 1, 10'h1ff);
    run(0, 2'h0, 1, 0, 1, 10'h2ff);
    run(0, 2'h0, 1, 0, 1, 10'h3ff);
    run(0, 2'h0, 0, 1, 1, 10'h001);
    run(0, 2'h0, 0, 1, 1, 10'h200);
    run(0, 2'h0, 0, 1, 1, 10'h300);
    run(1, 2'h0, 1, 0, 1, 10'h050);
    run(0, 2'h0, 0, 1, 1, 10'h050);
    for (int m = 1; m < 4; m++) run(0, 2'(m), 1, 0, 1, 10'h050);
    run(0, 2'h0, 1, 0, 0, 10'h050);
    run(0, 2'h0, 0, 0, 1, 10'h000);
    run(1, 2'h0, 0, 0, 1, 10'h250);
    for (int i = 0; i < 16; i++) begin
      r = $urandom % 3;
      run(1'($urandom), 2'($urandom), r == 1, r == 2, 1, 10'h002 + 10'($urandom % 496));
    end
    for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) cmp("pending responses", 48'h0, 48'(q.size()));
    test_done();
  end
endmodule // tb_paged_data_address_adjust
`default_nettype wire
